// ---- rdah_pkg.sv ----
// Purpose: Constants for the alarm-register I2C bus master controller.
// Assumes: 200 MHz system clock, 200 kHz fast-mode style SCL timing.
// Notes:   Device register map is that of the remote clock chip.
package rdah_pkg;
	localparam logic [6:0] DEV_ADDR        = 7'h32;
	localparam logic [3:0] REG_ALARM_MIN   = 4'hB;
	localparam logic [3:0] REG_ALARM_HOUR  = 4'hC;
	localparam logic [3:0] FMT_WRITE       = 4'h0;
	localparam logic [3:0] FMT_FAST_READ   = 4'h4;
	localparam logic [7:0] MIN_VALID_MASK  = 8'h7F;
	localparam logic [7:0] HOUR_VALID_MASK = 8'h3F;
	localparam logic [7:0] HOUR_PM_BIT     = 8'h20;
	// Avalon offsets (word index in low bits of address)
	localparam logic [1:0] OFS_CTRL        = 2'h0;
	localparam logic [1:0] OFS_STATUS      = 2'h1;
	localparam logic [1:0] OFS_MINUTE      = 2'h2;
	localparam logic [1:0] OFS_HOUR        = 2'h3;
	// Control bit positions
	localparam int CTRL_GO_WRITE = 0;
	localparam int CTRL_GO_READ  = 1;
	// Timing
	localparam int CLK_PERIOD_NS  = 5;
	localparam int QTR_PERIOD_NS  = 1250;
	localparam int QTR_CYCLES     = QTR_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage : rdah_pkg

// ---- rdah_bitphy.sv ----
// Purpose: Bit-level engine: start, stop, one byte plus acknowledge.
// Assumes: Open-drain lines; enables high pull the wire low.
// Notes:   SDA read back through two flip-flops before use.
`timescale 1ns/1ps
module rdah_bitphy (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [1:0] cmd_i,
	input  wire logic       cmd_valid_i,
	input  wire logic [7:0] tx_byte_i,
	input  wire logic       tx_ack_i,
	output logic            busy_o,
	output logic            done_o,
	output logic [7:0]      rx_byte_o,
	output logic            rx_ack_o,
	input  wire logic       sda_i,
	output logic            scl_o,
	output logic            scl_oe_o,
	output logic            sda_o,
	output logic            sda_oe_o
);
	// cmd: 0 start, 1 stop, 2 byte
	localparam int QC = rdah_pkg::QTR_CYCLES;
	logic [8:0]  tmr_q;
	logic [5:0]  ph_q;
	logic [1:0]  cmd_q;
	logic [8:0]  sh_q;
	logic        sda_m_q, sda_s_q;
	logic        scl_lo_q, sda_lo_q;
	logic        tick;
	logic [5:0]  last_ph;

	assign tick    = (tmr_q == 9'(QC - 1));
	assign last_ph = (cmd_q == 2'd2) ? 6'd35 : 6'd3;
	assign scl_o   = 1'b0;
	assign sda_o   = 1'b0;
	assign scl_oe_o = scl_lo_q;
	assign sda_oe_o = sda_lo_q;   // Only ever pulls low

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else begin
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			busy_o   <= 1'b0;
			done_o   <= 1'b0;
			tmr_q    <= '0;
			ph_q     <= '0;
			cmd_q    <= '0;
			sh_q     <= '0;
			scl_lo_q <= 1'b0;   // Both lines released at reset
			sda_lo_q <= 1'b0;
			rx_byte_o <= '0;
			rx_ack_o <= 1'b1;
		end else begin
			done_o <= 1'b0;
			if (!busy_o) begin
				// Ack let go one clock after SCL falls, never on the same edge
				if (cmd_q == 2'd2) begin
					sda_lo_q <= 1'b0;
				end
				if (cmd_valid_i) begin
					busy_o <= 1'b1;
					cmd_q  <= cmd_i;
					ph_q   <= '0;
					tmr_q  <= '0;
					sh_q   <= {tx_byte_i, tx_ack_i};
				end
			end else begin
				tmr_q <= tick ? 9'd0 : tmr_q + 9'd1;
				if (tick) begin
					unique case (cmd_q)
						2'd0: begin
							// SDA falls while SCL high works as repeated start
							unique case (ph_q[1:0])
								2'd0: begin
									sda_lo_q <= 1'b0;
									scl_lo_q <= 1'b0;
								end
								2'd1: sda_lo_q <= 1'b1;
								2'd2: scl_lo_q <= 1'b1;
								default: ;
							endcase
						end
						2'd1: begin
							// SDA rises while SCL high
							unique case (ph_q[1:0])
								2'd0: sda_lo_q <= 1'b1;
								2'd1: scl_lo_q <= 1'b0;
								2'd2: sda_lo_q <= 1'b0;
								default: ;
							endcase
						end
						default: begin
							// Data set only with SCL low 9th slot is ack
							unique case (ph_q[1:0])
								2'd0: sda_lo_q <= ~sh_q[8];
								2'd1: scl_lo_q <= 1'b0;
								2'd2: sh_q <= {sh_q[7:0], sda_s_q};
								default: scl_lo_q <= 1'b1;
							endcase
						end
					endcase
					if (ph_q == last_ph) begin
						busy_o <= 1'b0;
						done_o <= 1'b1;
						if (cmd_q == 2'd2) begin
							rx_byte_o <= sh_q[8:1];
							rx_ack_o  <= sh_q[0];
						end
					end else begin
						ph_q <= ph_q + 6'd1;
					end
				end
			end
		end
	end

	a_idle_released: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!busy_o && cmd_q == 2'd1) |-> (!scl_lo_q && !sda_lo_q))
		else $error("SCL held low while idle");
	a_data_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(cmd_q == 2'd2 && busy_o && !scl_lo_q && !$past(scl_lo_q)) |-> $stable(sda_lo_q))
		else $error("SDA moved while SCL high in a byte");
	a_done_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		done_o |=> !done_o)
		else $error("done longer than one cycle");
endmodule : rdah_bitphy

// ---- rdah_ctrl.sv ----
// Purpose: Avalon-controlled I2C master that writes and reads the daily alarm pair.
// Assumes: Single master, device at the fixed address, SCL not stretched.
// Notes:   Reads use the pointer-then-direct-read format to avoid a repeated start.
`timescale 1ns/1ps
// Operation
// - Software writes only real times into the alarm registers.
// - Both lines released high when no transfer runs.
// - Data changes only while clock is low.
// - Only the master issues start and stop; this controller does.
// - Data moves as 8-bit bytes, any number per access.
// - After each byte, sender releases data; receiver acks in ninth clock.
// - Acknowledging receiver releases data on ninth falling edge; this master lets go one clock after that edge.
// - Master withholds ack after last read byte, then stops.
// - First byte is 7-bit address MSB first plus direction bit.
// - Start before stop is a repeated start with a new address.
// - Write second byte holds pointer and format field; format 0000 for writes.
module rdah_ctrl (
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic [3:0]  AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	output logic [31:0]      AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	input  wire logic        SCL_I,
	output logic             SCL_O,
	output logic             SCL_OE_O,
	input  wire logic        SDA_I,
	output logic             SDA_O,
	output logic             SDA_OE_O
);
	typedef enum logic [9:0] {
		ST_IDLE  = 10'b0000000001,
		ST_START = 10'b0000000010,
		ST_ADDR  = 10'b0000000100,
		ST_PTR   = 10'b0000001000,
		ST_WMIN  = 10'b0000010000,
		ST_WHOUR = 10'b0000100000,
		ST_RMIN  = 10'b0001000000,
		ST_RHOUR = 10'b0010000000,
		ST_STOP  = 10'b0100000000,
		ST_WAIT  = 10'b1000000000
	} rdah_state_e;

	rdah_state_e st_q, ret_q;
	logic        rd_q;
	logic [7:0]  min_q, hour_q;
	logic [7:0]  rmin_q, rhour_q;
	logic        nack_q, done_q;
	logic [1:0]  cmd_q;
	logic        cmd_v_q;
	logic [7:0]  txb_q;
	logic        txa_q;
	logic        phy_busy, phy_done, phy_ack;
	logic [7:0]  phy_rx;
	logic        scl_m_q, scl_s_q;
	logic        busy;
	logic        unused_scl;
	logic [31:0] rdata;
	logic        rd_ack_q;

	// Valid-bit masking shared by write and read paths
	function automatic logic [7:0] fld_mask(input logic [7:0] v, input logic [7:0] m);
		fld_mask = v & m;
	endfunction : fld_mask

	assign busy = (st_q != ST_IDLE);
	// Writes other than to status stall while a transfer runs; reads wait one cycle for registered data
	assign AVS_WAITREQUEST_O = (AVS_READ_I && !rd_ack_q) ||
	                           (AVS_WRITE_I && busy && (AVS_ADDRESS_I[1:0] != rdah_pkg::OFS_STATUS));

	// SCL readback synchronised only for monitoring; no stretching support
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
		end else begin
			scl_m_q <= SCL_I;
			scl_s_q <= scl_m_q;
		end
	end
	assign unused_scl = scl_s_q;

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			min_q  <= rdah_pkg::RESET_BYTE;
			hour_q <= rdah_pkg::RESET_BYTE;
		end else if (AVS_WRITE_I && !AVS_WAITREQUEST_O) begin
			unique case (AVS_ADDRESS_I[1:0])
				// Upper bits forced zero before sending
				rdah_pkg::OFS_MINUTE: min_q <= fld_mask(AVS_WRITEDATA_I[7:0], rdah_pkg::MIN_VALID_MASK);
				rdah_pkg::OFS_HOUR:   hour_q <= fld_mask(AVS_WRITEDATA_I[7:0], rdah_pkg::HOUR_VALID_MASK);
				default: ;
			endcase
		end
	end

	always_comb begin
		rdata = 32'h0;
		unique case (AVS_ADDRESS_I[1:0])
			rdah_pkg::OFS_CTRL:   rdata = {31'h0, rd_q};
			rdah_pkg::OFS_STATUS: rdata = {29'h0, nack_q, done_q, busy};
			// Hour bit 5 passes through as PM flag or tens-twenty
			rdah_pkg::OFS_MINUTE: rdata = {24'h0, rmin_q};
			default:              rdata = {24'h0, rhour_q};
		endcase
	end

	// Read data from a flop; it stands while waitrequest is low
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			rd_ack_q       <= 1'b0;
			AVS_READDATA_O <= 32'h0;
		end else begin
			rd_ack_q       <= AVS_READ_I && !rd_ack_q;
			AVS_READDATA_O <= rdata;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			st_q    <= ST_IDLE;
			ret_q   <= ST_IDLE;
			rd_q    <= 1'b0;
			nack_q  <= 1'b0;
			done_q  <= 1'b0;
			cmd_q   <= 2'd0;
			cmd_v_q <= 1'b0;
			txb_q   <= 8'h00;
			txa_q   <= 1'b1;
			rmin_q  <= rdah_pkg::RESET_BYTE;   // Shown as zero until read back
			rhour_q <= rdah_pkg::RESET_BYTE;
		end else begin
			cmd_v_q <= 1'b0;
			unique case (st_q)
				ST_IDLE: begin
					if (AVS_WRITE_I && AVS_ADDRESS_I[1:0] == rdah_pkg::OFS_CTRL &&
					    (AVS_WRITEDATA_I[rdah_pkg::CTRL_GO_WRITE] ||
					     AVS_WRITEDATA_I[rdah_pkg::CTRL_GO_READ])) begin
						rd_q    <= AVS_WRITEDATA_I[rdah_pkg::CTRL_GO_READ];
						done_q  <= 1'b0;
						nack_q  <= 1'b0;
						cmd_q   <= 2'd0;   // Master alone creates start
						cmd_v_q <= 1'b1;
						st_q    <= ST_WAIT;
						ret_q   <= ST_START;
					end else if (AVS_WRITE_I && AVS_ADDRESS_I[1:0] == rdah_pkg::OFS_STATUS &&
					             AVS_WRITEDATA_I[1]) begin
						done_q <= 1'b0;
					end
				end
				ST_WAIT: begin
					if (phy_done) begin
						st_q <= ret_q;
					end
				end
				ST_START: begin
					// Address MSB first, direction write
					txb_q   <= {rdah_pkg::DEV_ADDR, 1'b0};
					txa_q   <= 1'b1;
					cmd_q   <= 2'd2;
					cmd_v_q <= 1'b1;
					st_q    <= ST_WAIT;
					ret_q   <= ST_ADDR;
				end
				ST_ADDR: begin
					if (phy_ack) begin
						// No ack from device: give up
						nack_q  <= 1'b1;
						cmd_q   <= 2'd1;
						cmd_v_q <= 1'b1;
						st_q    <= ST_WAIT;
						ret_q   <= ST_STOP;
					end else begin
						// Pointer plus format nibble
						txb_q   <= {rdah_pkg::REG_ALARM_MIN,
						            rd_q ? rdah_pkg::FMT_FAST_READ : rdah_pkg::FMT_WRITE};
						cmd_q   <= 2'd2;
						cmd_v_q <= 1'b1;
						st_q    <= ST_WAIT;
						ret_q   <= ST_PTR;
					end
				end
				ST_PTR: begin
					cmd_q   <= 2'd2;
					cmd_v_q <= 1'b1;
					st_q    <= ST_WAIT;
					if (phy_ack) begin
						nack_q  <= 1'b1;
						cmd_q   <= 2'd1;
						ret_q   <= ST_STOP;
					end else if (rd_q) begin
						// Master acks first data byte, releases line to receive
						txb_q <= 8'hFF;
						txa_q <= 1'b0;
						ret_q <= ST_RMIN;
					end else begin
						txb_q <= min_q;   // Software-supplied time
						ret_q <= ST_WMIN;
					end
				end
				ST_WMIN: begin
					// Device pointer now at hour register
					cmd_q   <= phy_ack ? 2'd1 : 2'd2;
					nack_q  <= phy_ack;
					txb_q   <= hour_q;
					cmd_v_q <= 1'b1;
					st_q    <= ST_WAIT;
					ret_q   <= phy_ack ? ST_STOP : ST_WHOUR;
				end
				ST_WHOUR: begin
					nack_q  <= phy_ack;
					cmd_q   <= 2'd1;
					cmd_v_q <= 1'b1;
					st_q    <= ST_WAIT;
					ret_q   <= ST_STOP;
				end
				ST_RMIN: begin
					rmin_q  <= fld_mask(phy_rx, rdah_pkg::MIN_VALID_MASK);
					// Last byte gets no ack
					txb_q   <= 8'hFF;
					txa_q   <= 1'b1;
					cmd_q   <= 2'd2;
					cmd_v_q <= 1'b1;
					st_q    <= ST_WAIT;
					ret_q   <= ST_RHOUR;
				end
				ST_RHOUR: begin
					rhour_q <= fld_mask(phy_rx, rdah_pkg::HOUR_VALID_MASK);
					cmd_q   <= 2'd1;   // Stop resets device pointer to F
					cmd_v_q <= 1'b1;
					st_q    <= ST_WAIT;
					ret_q   <= ST_STOP;
				end
				ST_STOP: begin
					done_q <= 1'b1;
					st_q   <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	rdah_bitphy u_phy (
		.clk_i       (CLK_I),
		.rst_n_i     (RST_N_I),
		.cmd_i       (cmd_q),
		.cmd_valid_i (cmd_v_q),
		.tx_byte_i   (txb_q),
		.tx_ack_i    (txa_q),
		.busy_o      (phy_busy),
		.done_o      (phy_done),
		.rx_byte_o   (phy_rx),
		.rx_ack_o    (phy_ack),
		.sda_i       (SDA_I),
		.scl_o       (SCL_O),
		.scl_oe_o    (SCL_OE_O),
		.sda_o       (SDA_O),
		.sda_oe_o    (SDA_OE_O)
	);

	a_min_mask: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		rmin_q[7] == 1'b0)
		else $error("minute bit 7 not zero");
	a_hour_mask: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		rhour_q[7:6] == 2'b00)
		else $error("hour upper bits not zero");
	a_sda_open: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		SDA_O == 1'b0)
		else $error("SDA driven high");
	a_idle_lines: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q == ST_IDLE && $past(st_q) == ST_IDLE) |-> (!SCL_OE_O && !SDA_OE_O))
		else $error("line held while idle");
	a_nack_stops: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q == ST_ADDR && phy_ack) |=> (ret_q == ST_STOP && cmd_q == 2'd1))
		else $error("nack not followed by stop");
	a_last_noack: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q == ST_RMIN) |=> (txa_q && ret_q == ST_RHOUR))
		else $error("last read byte acked");
	a_ptr_format: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q == ST_ADDR && !phy_ack) |=> (txb_q[7:4] == rdah_pkg::REG_ALARM_MIN &&
		 txb_q[3:0] == (rd_q ? rdah_pkg::FMT_FAST_READ : rdah_pkg::FMT_WRITE)))
		else $error("pointer byte wrong");
	a_addr_byte: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q == ST_START) |=> (txb_q == {rdah_pkg::DEV_ADDR, 1'b0}))
		else $error("address byte wrong");
	a_stop_done: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q == ST_STOP) |=> (done_q && st_q == ST_IDLE))
		else $error("done not set after stop");
	a_phy_free: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		cmd_v_q |-> !phy_busy)
		else $error("command issued while bit engine busy");
	a_scl_free: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(!SCL_OE_O && !$past(SCL_OE_O) && !$past(SCL_OE_O, 2)) |-> unused_scl)
		else $error("SCL low although released");
	a_go_starts: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q == ST_IDLE && AVS_WRITE_I && AVS_ADDRESS_I[1:0] == rdah_pkg::OFS_CTRL &&
		 (AVS_WRITEDATA_I[rdah_pkg::CTRL_GO_WRITE] || AVS_WRITEDATA_I[rdah_pkg::CTRL_GO_READ]))
		|=> (st_q == ST_WAIT && cmd_q == 2'd0 && !done_q))
		else $error("go did not start a transfer");
	c_write_done: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
		st_q == ST_STOP && !rd_q && !nack_q);
	c_read_done: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
		st_q == ST_STOP && rd_q && !nack_q);
	c_nack: cover property (@(posedge CLK_I) disable iff (!RST_N_I) nack_q && done_q);
endmodule : rdah_ctrl

// ---- rdah_dev_model.sv ----
// Purpose: Behavioural alarm clock chip on the far side of the two-wire bus.
// Assumes: Bench resolves the open-drain wires and feeds their levels in.
// Notes:   mute_i makes it deaf to its own address, so a nack can be provoked.
`timescale 1ns/1ps
module rdah_dev_model (
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic mute_i,
	output logic      sda_oe_o
);
	logic [7:0] regs [16];
	logic [7:0] sh;
	logic [3:0] ptr;
	logic [3:0] cnt;
	logic [2:0] st;
	logic [2:0] nxt;
	function automatic logic [7:0] keep(input logic [3:0] p);
		if (p == rdah_pkg::REG_ALARM_MIN)
			return rdah_pkg::MIN_VALID_MASK;
		if (p == rdah_pkg::REG_ALARM_HOUR)
			return rdah_pkg::HOUR_VALID_MASK;
		return 8'hFF;
	endfunction : keep
	// Power-up contents are arbitrary, but unused upper bits read 0
	initial begin
		st = 3'h0;
		cnt = 4'h0;
		ptr = 4'hF;
		sda_oe_o = 1'b0;
		for (int i = 0; i < 16; i++)
			regs[i] = 8'h5A & keep(4'(i));
	end
	// st: 0 ignoring, 1 address, 2 pointer, 3 write data, 4 read data
	always @(negedge sda_i) if (scl_i === 1'b1) begin
		st = 3'h1;
		cnt = 4'h0;
	end
	always @(posedge sda_i) if (scl_i === 1'b1) begin
		st = 3'h0;
		ptr = 4'hF;
	end
	// Edges taken off the resolved wires stand in for the part's synchronisers
	always @(posedge scl_i) if (st != 3'h0) begin
		if (cnt < 4'h8 && st != 3'h4)
			sh = {sh[6:0], sda_i};
		else if (cnt == 4'h8 && st == 3'h4 && sda_i)
			st = 3'h0;
		cnt = cnt + 4'h1;
	end
	// Drive changes only after the clock falls, so no false start or stop
	always @(negedge scl_i) if (st != 3'h0) begin
		if (cnt == 4'h8) begin
			sda_oe_o = st != 3'h4;
			nxt = 3'h4;
			if (st == 3'h1)
				nxt = sh[0] ? 3'h4 : 3'h2;
			if (st == 3'h1 && (sh[7:1] != rdah_pkg::DEV_ADDR || mute_i)) begin
				st = 3'h0;
				sda_oe_o = 1'b0;
			end
			if (st == 3'h2) begin
				ptr = sh[7:4];
				nxt = sh[3:0] == rdah_pkg::FMT_FAST_READ ? 3'h4 : 3'h3;
			end
			if (st == 3'h3) begin
				regs[ptr] = sh & keep(ptr);
				ptr = ptr + 4'h1;
				nxt = 3'h3;
			end
		end else if (cnt == 4'h9) begin
			sda_oe_o = 1'b0;
			cnt = 4'h0;
			st = nxt;
			if (st == 3'h4) begin
				sh = regs[ptr];
				ptr = ptr + 4'h1;
			end
		end
		if (st == 3'h4 && cnt < 4'h8)
			sda_oe_o = !sh[3'h7 - cnt[2:0]];
	end
endmodule : rdah_dev_model

// ---- rdah_ctrl_bench.sv ----
// Purpose: Self-checking bench for the alarm-pair bus controller.
// Assumes: Device model on the far side of the two-wire bus.
// Notes:   One transfer costs tens of thousands of cycles, so only a few run.
`timescale 1ns/1ps
module rdah_ctrl_bench;
	localparam logic [3:0] A_CTRL = {2'h0, rdah_pkg::OFS_CTRL};
	localparam logic [3:0] A_STAT = {2'h0, rdah_pkg::OFS_STATUS};
	localparam logic [3:0] A_MIN  = {2'h0, rdah_pkg::OFS_MINUTE};
	localparam logic [3:0] A_HOUR = {2'h0, rdah_pkg::OFS_HOUR};
	logic        CLK_I;
	logic        RST_N_I;
	logic [3:0]  AVS_ADDRESS_I;
	logic        AVS_READ_I;
	logic        AVS_WRITE_I;
	logic [31:0] AVS_WRITEDATA_I;
	logic [31:0] AVS_READDATA_O;
	logic        AVS_WAITREQUEST_O;
	logic        SCL_O;
	logic        SCL_OE_O;
	logic        SDA_O;
	logic        SDA_OE_O;
	logic        dev_oe;
	logic        mute;
	logic        scl_w;
	logic        sda_w;
	logic [31:0] seed;
	logic [31:0] rd;
	logic [7:0]  m1;
	logic [7:0]  h1;
	int          error_cnt;
	int          n_compared;
	int          cyc;
	// Pull-ups on both wires; any enable pulls low
	assign scl_w = !(SCL_OE_O === 1'b1);
	assign sda_w = !(SDA_OE_O === 1'b1 || dev_oe === 1'b1);
	rdah_ctrl u_dut (
		.CLK_I             (CLK_I),
		.RST_N_I           (RST_N_I),
		.AVS_ADDRESS_I     (AVS_ADDRESS_I),
		.AVS_READ_I        (AVS_READ_I),
		.AVS_WRITE_I       (AVS_WRITE_I),
		.AVS_WRITEDATA_I   (AVS_WRITEDATA_I),
		.AVS_READDATA_O    (AVS_READDATA_O),
		.AVS_WAITREQUEST_O (AVS_WAITREQUEST_O),
		.SCL_I             (scl_w),
		.SCL_O             (SCL_O),
		.SCL_OE_O          (SCL_OE_O),
		.SDA_I             (sda_w),
		.SDA_O             (SDA_O),
		.SDA_OE_O          (SDA_OE_O)
	);
	rdah_dev_model u_dev (.scl_i(scl_w), .sda_i(sda_w), .mute_i(mute), .sda_oe_o(dev_oe));
	initial begin
		CLK_I = 1'b0;
		forever #2.5 CLK_I = !CLK_I;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [7:0] bcd(input int v);
		return 8'((v / 10) * 16 + v % 10);
	endfunction : bcd
	function automatic logic [31:0] want(input logic [7:0] v, input logic [7:0] k);
		return {24'h0, v & k};
	endfunction : want
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Request held until waitrequest is seen low at a falling edge, then dropped after the next rising edge
	task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
		logic ok;
		@(posedge CLK_I);
		AVS_ADDRESS_I   <= a;
		AVS_WRITEDATA_I <= d;
		AVS_WRITE_I     <= w;
		AVS_READ_I      <= !w;
		do begin
			@(negedge CLK_I);
			ok = AVS_WAITREQUEST_O === 1'b0;
			rd = AVS_READDATA_O;
			@(posedge CLK_I);
		end while (!ok);
		AVS_WRITE_I <= 1'b0;
		AVS_READ_I  <= 1'b0;
	endtask : av
	task automatic wait_idle();
		do av(1'b0, A_STAT, 32'h0); while (rd[1:0] !== 2'b10);
	endtask : wait_idle
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	// Three transfers need about 90000 cycles
	always @(posedge CLK_I) begin
		cyc <= cyc + 1;
		if (cyc == 98000) begin
			error_cnt++;
			$display("[ERR] run length expected below %0d seen %0d", 98000, cyc);
			tally_and_finish();
		end
	end
	initial begin
		RST_N_I = 1'b0;
		AVS_ADDRESS_I = 4'h0;
		AVS_READ_I = 1'b0;
		AVS_WRITE_I = 1'b0;
		AVS_WRITEDATA_I = 32'h0;
		mute = 1'b0;
		error_cnt = 0;
		n_compared = 0;
		cyc = 0;
		seed = 32'h53E0;
		repeat (8) @(posedge CLK_I);
		RST_N_I <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			av(1'b0, 4'(i), 32'h0);
			chk("reset reg", 32'h0, rd);
		end
		chk("idle wires", 32'h3, {30'h0, scl_w, sda_w});
		repeat (5) seed = lfsr(seed);
		m1 = bcd(int'(seed[15:0] % 60));
		h1 = seed[16] ? 8'h32 : 8'h12;
		// Upper bits set on purpose: the chip must never keep them
		av(1'b1, A_MIN, {24'h0, m1 | 8'h80});
		av(1'b1, A_HOUR, {24'h0, h1 | 8'hC0});
		av(1'b1, A_CTRL, 32'h1);
		av(1'b0, A_STAT, 32'h0);
		chk("busy", 32'h1, rd & 32'h1);
		av(1'b1, A_MIN, 32'h0);
		av(1'b0, A_STAT, 32'h0);
		chk("stalled write", 32'h2, rd & 32'h7);
		chk("chip minute", want(m1 | 8'h80, rdah_pkg::MIN_VALID_MASK), u_dev.regs[11]);
		chk("chip hour", want(h1 | 8'hC0, rdah_pkg::HOUR_VALID_MASK), u_dev.regs[12]);
		av(1'b0, A_MIN, 32'h0);
		chk("minute before read", 32'h0, rd);
		av(1'b1, A_CTRL, 32'h2);
		wait_idle();
		av(1'b0, A_MIN, 32'h0);
		chk("read minute", want(m1, rdah_pkg::MIN_VALID_MASK), rd);
		av(1'b0, A_HOUR, 32'h0);
		chk("read hour", want(h1, rdah_pkg::HOUR_VALID_MASK), rd);
		av(1'b0, A_STAT, 32'h0);
		chk("read status", 32'h2, rd & 32'h7);
		av(1'b1, A_CTRL, 32'h0);
		av(1'b0, A_STAT, 32'h0);
		chk("no go bit", 32'h2, rd & 32'h7);
		av(1'b1, A_STAT, 32'h2);
		av(1'b0, A_STAT, 32'h0);
		chk("done cleared", 32'h0, rd & 32'h7);
		mute = 1'b1;
		av(1'b1, A_CTRL, 32'h1);
		wait_idle();
		chk("address nack", 32'h6, rd & 32'h7);
		chk("end wires", 32'h3, {30'h0, scl_w, sda_w});
		chk("low only", 32'h0, {30'h0, SCL_O, SDA_O});
		tally_and_finish();
	end
endmodule : rdah_ctrl_bench
